// *** plc_cluster.sv ***
// Cluster of sixteen logic cells with shared controls and AXI4-Lite setup.
`timescale 1ns/1ps

// What this block does
// - Each cell's table takes four inputs and gives any function of them.
// - Each cell register acts as a D, T, JK or SR flip-flop by setting.
// - The register has data, clock, clock enable and clear inputs.
// - Clock comes from global, pin or logic, clear from pin or logic; enable from pin or logic.
// - In combinational use the table result bypasses the register.
// - Three outputs choose the table result or the register output; row and column share one select.
// - Two outputs serve row, column and neighbour links, one local routing.
// - When a register is packed, the cluster synchronous load is ignored.
// - Feedback mode routes the register output into its own table.
// - Registered and unregistered table results are presented together.
// - A chain output feeds the next cell's register to build shift chains.
// - Sixteen cells form one cluster sharing controls and local routing.
// - Cluster controls give clock, clears and enable in every mode, and load unless the register is packed.
// - The chip-wide clear, when enabled, clears all and overrides all.
module plc_cluster (
  input  wire logic                      clk_sys,
  input  wire logic                      arst_n,
  input  wire logic                      chip_wide_clear_n,
  input  wire logic                      global_tick,
  input  wire logic                      pin_tick,
  input  wire logic                      pin_clr,
  input  wire logic                      pin_ena,
  input  wire logic [15:0]               cell_data_in,
  input  wire logic                      chain_in,
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic [15:0]                    local_out,
  output logic [15:0]                    row_out,
  output logic [15:0]                    col_out,
  output logic [15:0]                    lut_comb_out,
  output logic [15:0]                    reg_q_out,
  output logic                           chain_out
);
  import plc_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  logic [2:0]  pin_s1_reg;
  logic [2:0]  pin_s2_reg;
  logic [15:0] din_s1_reg;
  logic [15:0] din_s2_reg;
  logic [1:0]  gclr_s_reg;
  logic        chain_s1_reg;
  logic        chain_s2_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_reg   <= 3'h0;
      pin_s2_reg   <= 3'h0;
      din_s1_reg   <= 16'h0000;
      din_s2_reg   <= 16'h0000;
      gclr_s_reg   <= 2'h3;
      chain_s1_reg <= 1'b0;
      chain_s2_reg <= 1'b0;
    end else begin
      pin_s1_reg   <= {pin_ena, pin_clr, pin_tick};
      pin_s2_reg   <= pin_s1_reg;
      din_s1_reg   <= cell_data_in;
      din_s2_reg   <= din_s1_reg;
      gclr_s_reg   <= {gclr_s_reg[0], chip_wide_clear_n};
      chain_s1_reg <= chain_in;
      chain_s2_reg <= chain_s1_reg;
    end
  end

  // ==========================================================================
  // Configuration registers
  logic [31:0] lut_lo_reg;
  logic [31:0] lut_hi_reg;
  logic [31:0] regmode_reg;
  logic [31:0] outsel_reg;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [5:0]  clksrc_reg;
  logic [15:0] soft_data_reg;

  // ==========================================================================
  // AXI4-Lite slave
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic        aw_have_reg;
  logic        w_have_reg;
  logic        wr_fire;
  logic        wr_hit;

  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= RESET_WORD;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_have_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg   <= 1'b1;
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg   <= 1'b1;
        wdata_reg    <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    unique case (awaddr_reg)
      ADDR_LUT_LO, ADDR_LUT_HI, ADDR_REGMODE, ADDR_OUTSEL,
      ADDR_CTRL, ADDR_CLK_SRC, ADDR_DATA_IN: wr_hit = 1'b1;
      default:                               wr_hit = 1'b0;
    endcase
  end

  // Byte strobes are ignored; every register is written as a whole word.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lut_lo_reg    <= RESET_WORD;
      lut_hi_reg    <= RESET_WORD;
      regmode_reg   <= RESET_WORD;
      outsel_reg    <= RESET_WORD;
      ctrl_reg      <= '0;
      clksrc_reg    <= 6'h00;
      soft_data_reg <= 16'h0000;
    end else if (wr_fire) begin
      unique case (awaddr_reg)
        ADDR_LUT_LO:  lut_lo_reg    <= wdata_reg;
        ADDR_LUT_HI:  lut_hi_reg    <= wdata_reg;
        ADDR_REGMODE: regmode_reg   <= wdata_reg;
        ADDR_OUTSEL:  outsel_reg    <= wdata_reg;
        ADDR_CTRL:    ctrl_reg      <= wdata_reg[CTRL_W-1:0];
        ADDR_CLK_SRC: clksrc_reg    <= wdata_reg[5:0];
        ADDR_DATA_IN: soft_data_reg <= wdata_reg[15:0];
        default:      ;
      endcase
    end
  end

  // ==========================================================================
  // Cluster-wide controls
  logic tick_sel;
  logic clr_sel;
  logic ena_sel;
  logic gclr;
  logic [15:0] q_vec;
  logic [15:0] f_vec;

  assign gclr = ctrl_reg[CTRL_GCLR_EN] && !gclr_s_reg[1];

  always_comb begin
    unique case (plc_src_t'(clksrc_reg[1:0]))
      PLC_SRC_GLOBAL: tick_sel = global_tick;
      PLC_SRC_PIN:    tick_sel = pin_s2_reg[0];
      PLC_SRC_LOGIC:  tick_sel = f_vec[0];
      default:        tick_sel = 1'b1;
    endcase
    unique case (plc_src_t'(clksrc_reg[3:2]))
      PLC_SRC_GLOBAL: clr_sel = 1'b0;
      PLC_SRC_PIN:    clr_sel = pin_s2_reg[1];
      PLC_SRC_LOGIC:  clr_sel = f_vec[1];
      default:        clr_sel = 1'b0;
    endcase
    ena_sel = clksrc_reg[4] ? f_vec[2]
                            : (clksrc_reg[5] ? pin_s2_reg[2] : 1'b1);
  end

  // ==========================================================================
  // Cells
  logic [15:0] chain_vec;
  logic [15:0] lut_q;
  logic [15:0] lut_f;
  logic        sload_ok;

  // a packed register never takes the cluster synchronous load.
  assign sload_ok = ctrl_reg[CTRL_SLOAD] && !ctrl_reg[CTRL_PACKED];

  genvar gi;
  generate
    for (gi = 0; gi < CLUSTER_CELLS; gi++) begin : g_cell
      logic [3:0]  lut_in;
      logic [15:0] cfg;
      logic        dsrc;
      logic        prev_q;
      assign cfg = (gi % 2 == 1)
                   ? (gi < 8 ? lut_lo_reg[31:16] : lut_hi_reg[31:16])
                   : (gi < 8 ? lut_lo_reg[15:0]  : lut_hi_reg[15:0]);
      assign prev_q = (gi == 0) ? chain_s2_reg : q_vec[(gi + 15) % 16];
      assign lut_in = {ctrl_reg[CTRL_FEEDBACK] ? q_vec[gi] : soft_data_reg[gi],
                       din_s2_reg[gi], din_s2_reg[(gi + 1) % 16],
                       soft_data_reg[gi]};
      plc_lut4 u_lut (
        .cfg (cfg),
        .sel (lut_in),
        .f   (f_vec[gi])
      );
      assign dsrc = ctrl_reg[CTRL_CHAIN] ? prev_q : f_vec[gi];
      plc_storage u_reg (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .tick    (tick_sel),
        .mode    (plc_regmode_t'(regmode_reg[2*(gi%16) +: 2])),
        .d       (dsrc),
        .k       (din_s2_reg[gi]),
        .ena     (ena_sel),
        .clr     (gclr || clr_sel),
        .sclr    (ctrl_reg[CTRL_SCLR]),
        .sload   (sload_ok),
        .sload_d (soft_data_reg[gi]),
        .q       (q_vec[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Output routing, registered so every port comes from a flip-flop
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      local_out    <= 16'h0000;
      row_out      <= 16'h0000;
      col_out      <= 16'h0000;
      lut_comb_out <= 16'h0000;
      reg_q_out    <= 16'h0000;
      chain_out    <= 1'b0;
    end else begin
      for (int i = 0; i < CLUSTER_CELLS; i++) begin
        // bit set selects the register, clear selects the table.
        local_out[i] <= outsel_reg[i]      ? q_vec[i] : f_vec[i];
        row_out[i]   <= outsel_reg[16 + i] ? q_vec[i] : f_vec[i];
        col_out[i]   <= outsel_reg[16 + i] ? q_vec[i] : f_vec[i];
      end
      lut_comb_out <= f_vec;
      reg_q_out    <= q_vec;
      chain_out    <= q_vec[15];
    end
  end

  // ==========================================================================
  // Read channel
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= RESET_WORD;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= RESP_OKAY;
        unique case (s_axi_araddr)
          ADDR_LUT_LO:  s_axi_rdata <= lut_lo_reg;
          ADDR_LUT_HI:  s_axi_rdata <= lut_hi_reg;
          ADDR_REGMODE: s_axi_rdata <= regmode_reg;
          ADDR_OUTSEL:  s_axi_rdata <= outsel_reg;
          ADDR_CTRL:    s_axi_rdata <= {26'h0, ctrl_reg};
          ADDR_CLK_SRC: s_axi_rdata <= {26'h0, clksrc_reg};
          ADDR_DATA_IN: s_axi_rdata <= {16'h0, soft_data_reg};
          ADDR_STATUS:  s_axi_rdata <= {16'h0, q_vec};
          ADDR_LUT_OUT: s_axi_rdata <= {16'h0, f_vec};
          default: begin
            s_axi_rdata <= RESET_WORD;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// *** plc_pkg.sv ***
// Package with constants, enums and structs for the programmable logic cell.
package plc_pkg;

  // ==========================================================================
  // Geometry
  localparam int LUT_INPUTS    = 4;
  localparam int LUT_ENTRIES   = 16;
  localparam int CLUSTER_CELLS = 16;
  localparam int NUM_OUTS      = 3;

  // ==========================================================================
  // Register map (byte addresses, one aligned word each)
  localparam logic [7:0] ADDR_LUT_LO   = 8'h00;
  localparam logic [7:0] ADDR_LUT_HI   = 8'h04;
  localparam logic [7:0] ADDR_REGMODE  = 8'h08;
  localparam logic [7:0] ADDR_OUTSEL   = 8'h0C;
  localparam logic [7:0] ADDR_CTRL     = 8'h10;
  localparam logic [7:0] ADDR_CLK_SRC  = 8'h14;
  localparam logic [7:0] ADDR_DATA_IN  = 8'h18;
  localparam logic [7:0] ADDR_STATUS   = 8'h1C;
  localparam logic [7:0] ADDR_LUT_OUT  = 8'h20;

  // CTRL field positions.
  localparam int CTRL_FEEDBACK = 0;
  localparam int CTRL_PACKED   = 1;
  localparam int CTRL_CHAIN    = 2;
  localparam int CTRL_GCLR_EN  = 3;
  localparam int CTRL_SCLR     = 4;
  localparam int CTRL_SLOAD    = 5;
  localparam int CTRL_W        = 6;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [31:0] RESET_WORD  = 32'h0000_0000;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    PLC_MODE_D,
    PLC_MODE_T,
    PLC_MODE_JK,
    PLC_MODE_SR
  } plc_regmode_t;

  // Control source selection for clock and clear.
  typedef enum logic [1:0] {
    PLC_SRC_GLOBAL,
    PLC_SRC_PIN,
    PLC_SRC_LOGIC
  } plc_src_t;

  typedef struct packed {
    logic       clk_en;
    logic       aclr;
    logic       sclr;
    logic       sload;
    logic [3:0] sload_data;
  } plc_cluster_ctrl_t;

  typedef struct packed {
    logic lut_out;
    logic reg_out;
    logic local_out;
    logic row_out;
    logic col_out;
    logic chain_out;
  } plc_cell_out_t;

endpackage

// *** plc_lut4.sv ***
// Four-input look-up table driven by sixteen configuration bits.
`timescale 1ns/1ps

module plc_lut4 (
  input  wire logic [15:0] cfg,
  input  wire logic [3:0]  sel,
  output logic             f
);
  import plc_pkg::*;

  assign f = cfg[sel];

endmodule

// *** plc_storage.sv ***
// Configurable storage element with D, T, JK and SR behaviour.
`timescale 1ns/1ps

module plc_storage (
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  input  wire logic                  tick,
  input  wire plc_pkg::plc_regmode_t mode,
  input  wire logic                  d,
  input  wire logic                  k,
  input  wire logic                  ena,
  input  wire logic                  clr,
  input  wire logic                  sclr,
  input  wire logic                  sload,
  input  wire logic                  sload_d,
  output logic                       q
);
  import plc_pkg::*;

  logic q_reg;
  logic q_next;

  always_comb begin
    q_next = q_reg;
    if (sclr) begin
      q_next = 1'b0;
    end else if (sload) begin
      q_next = sload_d;
    end else begin
      unique case (mode)
        PLC_MODE_D:  q_next = d;
        PLC_MODE_T:  q_next = q_reg ^ d;
        PLC_MODE_JK: q_next = (d & ~q_reg) | (~k & q_reg);
        PLC_MODE_SR: q_next = d ? 1'b1 : (k ? 1'b0 : q_reg);
      endcase
    end
  end

  // Clear is held as a level each cycle so it forces zero while asserted.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q_reg <= 1'b0;
    end else if (clr) begin
      q_reg <= 1'b0;
    end else if (tick && ena) begin
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

endmodule

// *** plc_cluster_assertions.sv ***
// Concurrent checks on the cluster ports, bound to every cluster instance.
`timescale 1ns/1ps

module plc_cluster_assertions (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        chip_wide_clear_n,
  input wire logic        pin_clr,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic [15:0] local_out,
  input wire logic [15:0] row_out,
  input wire logic [15:0] lut_comb_out,
  input wire logic [15:0] reg_q_out
);
  import plc_pkg::*;
  logic [7:0]  aw_q;
  logic [7:0]  wa;
  logic [5:0]  ctrl_q;
  logic [1:0]  clr_src_q;
  logic [31:0] osel_q;

  // ==========================================================================
  // Shadow of setup writes; the address may be taken on the same edge as the data or an earlier one.
  assign wa = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aw_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_q <= s_axi_awaddr;
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= 6'h00;
      clr_src_q <= 2'h0;
      osel_q <= 32'h00000000;
    end else if (s_axi_wvalid && s_axi_wready) begin
      if (wa == ADDR_CTRL) ctrl_q <= s_axi_wdata[5:0];
      if (wa == ADDR_CLK_SRC) clr_src_q <= s_axi_wdata[3:2];
      if (wa == ADDR_OUTSEL) osel_q <= s_axi_wdata;
    end
  end

  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_bfast;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_bfast: assert property (p_bfast) else $error("write answer late");
  property p_rfast;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rfast: assert property (p_rfast) else $error("read answer late");
  property p_slverr;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > ADDR_LUT_OUT
      |=> s_axi_rresp == RESP_SLVERR;
  endproperty
  a_slverr: assert property (p_slverr) else $error("hole read not refused");
  property p_awlock;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  a_awlock: assert property (p_awlock) else $error("address taken early");
  property p_gclr;
    (ctrl_q[3] && !chip_wide_clear_n) [*6] |-> reg_q_out == 16'h0000;
  endproperty
  a_gclr: assert property (p_gclr) else $error("chip clear ignored");
  property p_pclr;
    (clr_src_q == 2'h1 && pin_clr) [*6] |-> reg_q_out == 16'h0000;
  endproperty
  a_pclr: assert property (p_pclr) else $error("pin clear ignored");
  property p_lsel;
    (osel_q[15:0] == 16'h0000 && $stable(lut_comb_out)) [*4]
      |-> local_out == lut_comb_out;
  endproperty
  a_lsel: assert property (p_lsel) else $error("local not table");
  property p_lreg;
    (osel_q[15:0] == 16'hFFFF && $stable(reg_q_out)) [*4]
      |-> local_out == reg_q_out;
  endproperty
  a_lreg: assert property (p_lreg) else $error("local not register");
  property p_rsel;
    (osel_q[31:16] == 16'h0000 && $stable(lut_comb_out)) [*4]
      |-> row_out == lut_comb_out;
  endproperty
  a_rsel: assert property (p_rsel) else $error("row not table");
endmodule

bind plc_cluster plc_cluster_assertions u_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .chip_wide_clear_n(chip_wide_clear_n),
  .pin_clr(pin_clr), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .local_out(local_out), .row_out(row_out),
  .lut_comb_out(lut_comb_out), .reg_q_out(reg_q_out)
);

// *** plc_cluster_tb_top.sv ***
// Self-checking testbench of the logic cell cluster.
`timescale 1ns/1ps

module plc_cluster_tb_top;
  import plc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        arst_n, chip_wide_clear_n, global_tick, pin_tick, pin_clr;
  logic        pin_ena, chain_in, chain_out;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [15:0] cell_data_in, local_out, row_out, col_out, lut_comb_out;
  logic [15:0] reg_q_out, kv;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [31:0] seed = 32'h150B8D5D;
  int          fails = 0;
  int          checked = 0;
  int          exp_q;

  always #2.5 clk_sys = ~clk_sys;

  plc_cluster uut (
    .clk_sys(clk_sys), .arst_n(arst_n), .chip_wide_clear_n(chip_wide_clear_n),
    .global_tick(global_tick), .pin_tick(pin_tick), .pin_clr(pin_clr),
    .pin_ena(pin_ena), .cell_data_in(cell_data_in), .chain_in(chain_in),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .local_out(local_out), .row_out(row_out),
    .col_out(col_out), .lut_comb_out(lut_comb_out), .reg_q_out(reg_q_out),
    .chain_out(chain_out)
  );

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rresp", 32'(er), 32'(s_axi_rresp));
    chk("rdata", e, s_axi_rdata);
  endtask

  task automatic settle();
    repeat (6) @(posedge clk_sys);
  endtask

  // One global clock tick to every cell register, with fresh pin data.
  task automatic tk();
    @(posedge clk_sys);
    cell_data_in <= 16'(xs());
    global_tick <= 1'b1;
    @(posedge clk_sys);
    global_tick <= 1'b0;
    settle();
  endtask

  task automatic lut(input logic [31:0] v);
    wr(ADDR_LUT_LO, v, RESP_OKAY);
    wr(ADDR_LUT_HI, v, RESP_OKAY);
  endtask

  task automatic conclude();
    $display("checks %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    conclude();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {arst_n, global_tick, pin_tick, pin_clr, pin_ena, chain_in} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    chip_wide_clear_n = 1'b1;
    cell_data_in = 16'h0000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int a = 0; a <= 32; a += 4) rd(8'(a), RESET_WORD, RESP_OKAY);
    rd(8'h24, 32'h00000000, RESP_SLVERR);
    rd(8'hFC, 32'h00000000, RESP_SLVERR);
    wr(8'h40, 32'h12345678, RESP_SLVERR);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_REGMODE, {16{2'(m)}}, RESP_OKAY);
      rd(ADDR_REGMODE, {16{2'(m)}}, RESP_OKAY);
    end
    rv = xs();
    wr(ADDR_OUTSEL, rv, RESP_OKAY);
    rd(ADDR_OUTSEL, rv, RESP_OKAY);
    rv = xs();
    wr(ADDR_CTRL, rv, RESP_OKAY);
    rd(ADDR_CTRL, rv & 32'h0000003F, RESP_OKAY);
    wr(ADDR_CTRL, 32'h00000000, RESP_OKAY);
    wr(ADDR_OUTSEL, 32'h00000000, RESP_OKAY);
    wr(ADDR_REGMODE, 32'h00000000, RESP_OKAY);
    wr(ADDR_CLK_SRC, 32'h00000024, RESP_OKAY);
    lut(32'hFFFFFFFF);
    pin_ena <= 1'b1;
    settle();
    exp_q = 0;
    chk("lut", 32'h0000FFFF, 32'(lut_comb_out));
    chk("local", 32'h0000FFFF, 32'(local_out));
    chk("q", 32'(exp_q), 32'(reg_q_out));
    rd(ADDR_LUT_OUT, 32'h0000FFFF, RESP_OKAY);
    tk();
    exp_q = 16'hFFFF;
    chk("q", 32'(exp_q), 32'(reg_q_out));
    lut(32'h00000000);
    wr(ADDR_OUTSEL, 32'h0000FFFF, RESP_OKAY);
    settle();
    chk("local", 32'(exp_q), 32'(local_out));
    chk("row", 32'h00000000, 32'(row_out));
    chk("col", 32'h00000000, 32'(col_out));
    chk("lut", 32'h00000000, 32'(lut_comb_out));
    rd(ADDR_STATUS, 32'(exp_q), RESP_OKAY);
    pin_clr <= 1'b1;
    settle();
    chk("q", 32'h00000000, 32'(reg_q_out));
    tk();
    chk("q", 32'h00000000, 32'(reg_q_out));
    pin_clr <= 1'b0;
    exp_q = 0;
    wr(ADDR_REGMODE, 32'h55555555, RESP_OKAY);
    lut(32'hFFFFFFFF);
    for (int i = 0; i < 3; i++) begin
      tk();
      exp_q ^= 16'hFFFF;
      chk("q", 32'(exp_q), 32'(reg_q_out));
    end
    pin_ena <= 1'b0;
    settle();
    tk();
    chk("q", 32'(exp_q), 32'(reg_q_out));
    pin_ena <= 1'b1;
    wr(ADDR_CTRL, 32'h00000008, RESP_OKAY);
    chip_wide_clear_n <= 1'b0;
    settle();
    chk("q", 32'h00000000, 32'(reg_q_out));
    tk();
    chk("q", 32'h00000000, 32'(reg_q_out));
    wr(ADDR_CTRL, 32'h00000000, RESP_OKAY);
    tk();
    exp_q = 16'hFFFF;
    chk("q", 32'(exp_q), 32'(reg_q_out));
    chip_wide_clear_n <= 1'b1;
    wr(ADDR_CTRL, 32'h00000010, RESP_OKAY);
    tk();
    chk("q", 32'h00000000, 32'(reg_q_out));
    wr(ADDR_REGMODE, 32'h00000000, RESP_OKAY);
    wr(ADDR_CTRL, 32'h00000022, RESP_OKAY);
    tk();
    chk("q", 32'h0000FFFF, 32'(reg_q_out));
    pin_clr <= 1'b1;
    settle();
    pin_clr <= 1'b0;
    lut(32'h00000000);
    wr(ADDR_CTRL, 32'h00000004, RESP_OKAY);
    chain_in <= 1'b1;
    settle();
    exp_q = 0;
    for (int k = 0; k < 16; k++) begin
      tk();
      exp_q = ((exp_q << 1) | 1) & 16'hFFFF;
      chk("q", 32'(exp_q), 32'(reg_q_out));
    end
    chk("lut", 32'h00000000, 32'(lut_comb_out));
    chk("chain", 32'h00000001, 32'(chain_out));
    wr(ADDR_CTRL, 32'h00000001, RESP_OKAY);
    lut(32'hFF00FF00);
    settle();
    chk("lut", 32'h0000FFFF, 32'(lut_comb_out));
    for (int i = 0; i < 6; i++) begin
      if (i % 3 == 0) begin
        wr(ADDR_REGMODE, (i == 0) ? 32'hAAAAAAAA : 32'hFFFFFFFF, RESP_OKAY);
        lut((i == 0) ? 32'hFFFFFFFF : 32'h00000000);
      end
      kv = cell_data_in;
      tk();
      exp_q = (i < 3) ? 16'(~exp_q | ~kv) : 16'(exp_q & ~kv);
      chk("q", 32'(exp_q), 32'(reg_q_out));
    end
    conclude();
  end
endmodule
